// file: include/sac_pkg.sv
/*
  Constants, command codes and state type for the SRAM auto-step controller.
  Assumes a single 25 MHz system clock and a host that drives command and data pins.
*/
// Behaviour
// RQ1 - Reset waits in configuration, stores 4-bit program
// RQ2 - After capture, move to run state
// RQ3 - Capture low four data bits on strobe
// RQ4 - Run decodes command: latch, read or write
// RQ5 - Low latch loads address bits 7..0
// RQ6 - High latch loads 15..8, clears top three
// RQ7 - Read requests SRAM, then steps per read config
// RQ8 - Write requests SRAM, then steps per write config
// RQ9 - One 19-bit counter is address and stepper
// RQ10 - SRAM controls combinational from command lines, clock
// RQ11 - Run state held until reset
// RQ12 - State and counter clocked by system clock
// RQ13 - Codes: 00 write, 01 read, 10 low, 11 high
// RQ14 - Separate read/write sign and one-bit step size
// RQ15 - Reset clears counter, config, forces configuration
// RQ16 - Step is exactly one, wraps modulo 2^19
package sac_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int CFG_W = 4;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // Command codes {cmd_bit_high, cmd_bit_low}
  // ----------------------------------------------------------------
  localparam logic [1:0] CMD_WRITE = 2'h0;
  localparam logic [1:0] CMD_READ = 2'h1;
  localparam logic [1:0] CMD_LOAD_LOW = 2'h2;
  localparam logic [1:0] CMD_LOAD_HIGH = 2'h3;

  // ----------------------------------------------------------------
  // Configuration bit positions
  // ----------------------------------------------------------------
  localparam int CFG_WRITE_STEP_SIZE = 0;
  localparam int CFG_WRITE_STEP_SIGN = 1;
  localparam int CFG_READ_STEP_SIZE = 2;
  localparam int CFG_READ_STEP_SIGN = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RESET = 19'h00000;
  localparam logic [CFG_W-1:0] CFG_RESET = 4'h0;

  typedef enum logic [0:0] {
    SAC_CONFIG,
    SAC_RUN
  } sac_state_t;

endpackage

// file: rtl/sac_fifo.sv
/*
  Parameterised synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ns
module sac_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign in_ready_o = (count != DEPTH[PW:0]);
  assign out_valid_o = (count != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr];

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// file: rtl/sac_sync.sv
/*
  Two-flop synchroniser for a bundle of pin inputs.
  Assumes asynchronous pins; the first stage feeds only the second.
*/
`timescale 1ns/1ns
module sac_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule

// file: rtl/sac_controller.sv
/*
  SRAM controller with a configuration program and a post-stepping 19-bit address counter.
  Host command and data pins are synchronised; write bytes pass an 8-word FIFO before the
  SRAM port; the SRAM side may stall the FIFO, which back-pressures the host through
  host_ready_o.
*/
`timescale 1ns/1ns
module sac_controller
  import sac_pkg::*;
#(
  parameter int FIFO_DEPTH_P = sac_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Host command pins
  input wire logic cmd_bit_low_i,
  input wire logic cmd_bit_high_i,
  input wire logic cmd_strobe_i,
  input wire logic [sac_pkg::DATA_W-1:0] host_data_i,
  output logic host_ready_o,
  // SRAM combinational controls
  output logic sram_cs_n_o,
  output logic cmd_bit_low_n_o,
  output logic cmd_bit_high_n_o,
  // SRAM request port
  output logic [sac_pkg::ADDR_W-1:0] sram_addr_o,
  output logic sram_write_valid_o,
  output logic [sac_pkg::DATA_W-1:0] sram_write_data_o,
  input wire logic sram_write_ready_i,
  output logic sram_read_req_o,
  // Status
  output logic run_o,
  output logic [sac_pkg::CFG_W-1:0] config_o
);
  import sac_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [DATA_W+2:0] pins_sync;
  logic cmd_low;
  logic cmd_high;
  logic strobe;
  logic [DATA_W-1:0] data;
  logic [1:0] cmd;

  sac_sync #(
    .WIDTH(DATA_W + 3)
  ) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_i({cmd_strobe_i, cmd_bit_high_i, cmd_bit_low_i, host_data_i}),
    .sync_o(pins_sync)
  );

  assign data = pins_sync[DATA_W-1:0];
  assign cmd_low = pins_sync[DATA_W];
  assign cmd_high = pins_sync[DATA_W+1];
  assign strobe = pins_sync[DATA_W+2];
  assign cmd = {cmd_high, cmd_low};

  // ----------------------------------------------------------------
  // SRAM control gating
  // ----------------------------------------------------------------
  // Raw pins and clock, unregistered, so the SRAM sees no added delay
  assign sram_cs_n_o = ~(~cmd_bit_high_i & ~clock_i); // RQ10
  assign cmd_bit_low_n_o = ~cmd_bit_low_i; // RQ10
  assign cmd_bit_high_n_o = ~cmd_bit_high_i; // RQ10

  // ----------------------------------------------------------------
  // State and configuration
  // ----------------------------------------------------------------
  sac_state_t state;
  logic [CFG_W-1:0] config_bits;
  logic take;

  // Write commands wait while the FIFO is full
  logic fifo_in_ready;
  assign take = strobe && !(cmd == CMD_WRITE && state == SAC_RUN && !fifo_in_ready);
  assign host_ready_o = fifo_in_ready;

  always_ff @(posedge clock_i or posedge rst_i) begin // RQ12
    if (rst_i) begin
      state <= SAC_CONFIG; // RQ15
    end else begin
      case (state)
        SAC_CONFIG: begin
          if (take && cmd == CMD_WRITE) begin // RQ13
            state <= SAC_RUN; // RQ2
          end
        end
        SAC_RUN: begin
          state <= SAC_RUN; // RQ11
        end
        default: begin
          state <= SAC_CONFIG;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      config_bits <= CFG_RESET; // RQ15
    end else if (state == SAC_CONFIG && take && cmd == CMD_WRITE) begin // RQ1
      config_bits <= data[CFG_W-1:0]; // RQ3
    end
  end

  assign run_o = (state == SAC_RUN);
  assign config_o = config_bits;

  // ----------------------------------------------------------------
  // Address counter
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] next_addr;

  function automatic logic [ADDR_W-1:0] step_addr(
    input logic [ADDR_W-1:0] a,
    input logic sign,
    input logic size
  );
    if (!size) begin
      step_addr = a;
    end else if (sign) begin
      step_addr = a + 19'h00001; // RQ16
    end else begin
      step_addr = a - 19'h00001; // RQ16
    end
  endfunction

  always_comb begin
    next_addr = addr;
    if (state == SAC_RUN && take) begin
      case (cmd) // RQ4
        CMD_LOAD_LOW: begin
          next_addr = {addr[ADDR_W-1:DATA_W], data}; // RQ5
        end
        CMD_LOAD_HIGH: begin
          next_addr = {3'h0, data, addr[DATA_W-1:0]}; // RQ6
        end
        CMD_READ: begin
          next_addr = step_addr(addr, config_bits[CFG_READ_STEP_SIGN],
                                config_bits[CFG_READ_STEP_SIZE]); // RQ7 RQ14
        end
        CMD_WRITE: begin
          next_addr = step_addr(addr, config_bits[CFG_WRITE_STEP_SIGN],
                                config_bits[CFG_WRITE_STEP_SIZE]); // RQ8 RQ14
        end
        default: begin
          next_addr = addr;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin // RQ9 RQ12
    if (rst_i) begin
      addr <= ADDR_RESET; // RQ15
    end else begin
      addr <= next_addr;
    end
  end

  // ----------------------------------------------------------------
  // Read request
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] read_addr;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sram_read_req_o <= 1'b0;
      read_addr <= ADDR_RESET;
    end else begin
      sram_read_req_o <= state == SAC_RUN && take && cmd == CMD_READ; // RQ7
      if (state == SAC_RUN && take && cmd == CMD_READ) begin
        read_addr <= addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write path through FIFO
  // ----------------------------------------------------------------
  logic [ADDR_W+DATA_W-1:0] fifo_out;
  logic fifo_in_valid;

  assign fifo_in_valid = state == SAC_RUN && strobe && cmd == CMD_WRITE; // RQ8

  sac_fifo #(
    .WIDTH(ADDR_W + DATA_W),
    .DEPTH(FIFO_DEPTH_P)
  ) u_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i({addr, data}),
    .out_valid_o(sram_write_valid_o),
    .out_ready_i(sram_write_ready_i),
    .out_data_o(fifo_out)
  );

  assign sram_write_data_o = fifo_out[DATA_W-1:0];
  assign sram_addr_o = sram_write_valid_o ? fifo_out[ADDR_W+DATA_W-1:DATA_W] : read_addr;
endmodule

// file: verification/sac_controller_assertions.sv
/* Port checker for sac_controller.
   Assumes pins change just after the rising clock edge. */
`timescale 1ns/1ns
module sac_checker (
  // Controller ports
  input wire logic clock_i, rst_i, cmd_bit_low_i, cmd_bit_high_i, cmd_strobe_i,
  input wire logic [7:0] host_data_i,
  input wire logic sram_cs_n_o, cmd_bit_low_n_o, cmd_bit_high_n_o,
  input wire logic [18:0] sram_addr_o,
  input wire logic sram_write_valid_o, sram_write_ready_i, sram_read_req_o, run_o,
  input wire logic [7:0] sram_write_data_o,
  input wire logic [3:0] config_o
);
  wire logic cfg_pin = cmd_strobe_i & ~cmd_bit_high_i & ~cmd_bit_low_i;
  wire logic rd_pin = cmd_strobe_i & ~cmd_bit_high_i & cmd_bit_low_i;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Clock is low in the sampled values, so select follows the pin
  a_cs_follow: assert property (sram_cs_n_o == cmd_bit_high_i)
    else $error("chip select wrong");
  a_inv_lines: assert property (cmd_bit_low_n_o == !cmd_bit_low_i && cmd_bit_high_n_o == !cmd_bit_high_i)
    else $error("inverted lines wrong");
  // Clock is high in the sampled values, so select must be inactive
  a_cs_clk_high: assert property (@(negedge clock_i) sram_cs_n_o)
    else $error("chip select active with clock high");
  a_cfg_capture: assert property (($past(cfg_pin, 3) && !$past(run_o)) |-> run_o && config_o == $past(host_data_i[3:0], 3))
    else $error("program not captured");
  a_cfg_wait: assert property ((!$past(cfg_pin, 3) && !$past(run_o)) |-> !run_o)
    else $error("left configuration early");
  a_run_held: assert property (run_o |=> run_o)
    else $error("run state lost");
  a_read_req: assert property (sram_read_req_o == ($past(run_o) && $past(rd_pin, 3)))
    else $error("read request wrong");
  a_reset_clear: assert property ($fell(rst_i) |-> !run_o && config_o == 4'h0 && sram_addr_o == 19'h00000)
    else $error("reset values wrong");
  a_write_hold: assert property (sram_write_valid_o && !sram_write_ready_i |=>
    sram_write_valid_o && $stable(sram_write_data_o) && $stable(sram_addr_o))
    else $error("write word dropped");
endmodule
bind sac_controller sac_checker sac_checker_inst (.clock_i(clock_i), .rst_i(rst_i),
  .cmd_bit_low_i(cmd_bit_low_i), .cmd_bit_high_i(cmd_bit_high_i), .cmd_strobe_i(cmd_strobe_i),
  .host_data_i(host_data_i), .sram_cs_n_o(sram_cs_n_o), .cmd_bit_low_n_o(cmd_bit_low_n_o),
  .cmd_bit_high_n_o(cmd_bit_high_n_o), .sram_addr_o(sram_addr_o), .sram_write_valid_o(sram_write_valid_o),
  .sram_write_ready_i(sram_write_ready_i), .sram_read_req_o(sram_read_req_o), .run_o(run_o),
  .sram_write_data_o(sram_write_data_o), .config_o(config_o));

// file: verification/sac_sram_model.sv
/* SRAM-side partner: takes FIFO words, logs writes and reads.
   Assumes reads are issued while the write FIFO is empty. */
`timescale 1ns/1ns
module sac_sram_model
  import sac_pkg::*;
(
  // Clock and stall control
  input wire logic clock_i,
  input wire logic stall_i,
  // SRAM request port
  input wire logic [sac_pkg::ADDR_W-1:0] sram_addr_i,
  input wire logic sram_write_valid_i,
  input wire logic [sac_pkg::DATA_W-1:0] sram_write_data_i,
  input wire logic sram_read_req_i,
  output logic sram_write_ready_o
);
  logic [27:0] log_q[$];
  initial sram_write_ready_o = 1'b1;
  // Log entry: kind, address, data
  always @(posedge clock_i) begin
    sram_write_ready_o <= !stall_i;
    if (sram_write_valid_i && sram_write_ready_o) log_q.push_back({1'b1, sram_addr_i, sram_write_data_i});
    if (sram_read_req_i) log_q.push_back({1'b0, sram_addr_i, 8'h00});
  end
endmodule

// file: verification/tb_top.sv
/* Self-checking bench for sac_controller.
   Assumes the SRAM partner model logs every access. */
`timescale 1ns/1ns
module tb_top;
  import sac_pkg::*;
  logic clock_i = 1'b0, rst_i = 1'b1, cmd_bit_low_i = 1'b0, cmd_bit_high_i = 1'b0, cmd_strobe_i = 1'b0;
  logic stall = 1'b0;
  logic [7:0] host_data_i = 8'h00;
  logic host_ready_o, sram_cs_n_o, cmd_bit_low_n_o, cmd_bit_high_n_o, sram_write_valid_o;
  logic sram_write_ready_i, sram_read_req_o, run_o;
  logic [18:0] sram_addr_o, addr;
  logic [7:0] sram_write_data_o;
  logic [3:0] config_o, cfg_now;
  logic [3:0] cfg_list[4] = '{4'hF, 4'h5, 4'h7, 4'hA};
  logic [27:0] exp_q[$];
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  always #20 clock_i = ~clock_i;
  sac_controller sac_controller_inst (.clock_i(clock_i), .rst_i(rst_i), .cmd_bit_low_i(cmd_bit_low_i),
    .cmd_bit_high_i(cmd_bit_high_i), .cmd_strobe_i(cmd_strobe_i), .host_data_i(host_data_i),
    .host_ready_o(host_ready_o), .sram_cs_n_o(sram_cs_n_o), .cmd_bit_low_n_o(cmd_bit_low_n_o),
    .cmd_bit_high_n_o(cmd_bit_high_n_o), .sram_addr_o(sram_addr_o), .sram_write_valid_o(sram_write_valid_o),
    .sram_write_data_o(sram_write_data_o), .sram_write_ready_i(sram_write_ready_i),
    .sram_read_req_o(sram_read_req_o), .run_o(run_o), .config_o(config_o));
  sac_sram_model sac_sram_model_inst (.clock_i(clock_i), .stall_i(stall), .sram_addr_i(sram_addr_o),
    .sram_write_valid_i(sram_write_valid_o), .sram_write_data_i(sram_write_data_o),
    .sram_read_req_i(sram_read_req_o), .sram_write_ready_o(sram_write_ready_i));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Strobe stays high so back-to-back commands need no gap
  task automatic cmd(input logic [1:0] c, input logic [7:0] d);
    {cmd_bit_high_i, cmd_bit_low_i} = c;
    host_data_i = d;
    cmd_strobe_i = 1'b1;
    @(posedge clock_i) #1;
  endtask
  task automatic idle(input int n);
    cmd_strobe_i = 1'b0;
    repeat (n) @(posedge clock_i) #1;
  endtask
  function automatic logic [18:0] step(input logic [18:0] a, input logic sign, input logic size);
    if (!size) return a;
    return sign ? a + 19'h00001 : a - 19'h00001;
  endfunction
  task automatic wr(input logic [7:0] d);
    cmd(CMD_WRITE, d);
    exp_q.push_back({1'b1, addr, d});
    addr = step(addr, cfg_now[1], cfg_now[0]);
  endtask
  task automatic rd();
    idle(4);
    cmd(CMD_READ, 8'h00);
    exp_q.push_back({1'b0, addr, 8'h00});
    addr = step(addr, cfg_now[3], cfg_now[2]);
  endtask
  task automatic do_reset(input logic [3:0] cfg);
    rst_i = 1'b1;
    idle(10);
    rst_i = 1'b0;
    cfg_now = cfg;
    sac_sram_model_inst.log_q.delete();
    exp_q.delete();
    check({run_o, host_ready_o, config_o, sram_addr_o}, {1'b0, 1'b1, 4'h0, 19'h00000});
    cmd(CMD_READ, 8'hFF);
    idle(5);
    check(run_o, 1'b0);
    cmd(CMD_WRITE, {4'hA, cfg});
    idle(5);
    check({run_o, config_o}, {1'b1, cfg});
  endtask
  task automatic compare_log();
    idle(10);
    check(sac_sram_model_inst.log_q.size(), exp_q.size());
    foreach (exp_q[i]) check(sac_sram_model_inst.log_q[i], exp_q[i]);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Steps from zero, so decrement wraps and high latch clears top bits
  task automatic run_modes(input logic [3:0] cfg);
    do_reset(cfg);
    cmd(CMD_LOAD_LOW, 8'h00);
    cmd(CMD_LOAD_HIGH, 8'h00);
    addr = 19'h00000;
    wr(8'hA5);
    wr(8'h5A);
    rd();
    rd();
    cmd(CMD_LOAD_HIGH, 8'h12);
    addr = {3'b000, 8'h12, addr[7:0]};
    wr(8'hC3);
    cmd(CMD_LOAD_LOW, 8'h34);
    addr = {addr[18:8], 8'h34};
    wr(8'h3C);
    compare_log();
  endtask
  task automatic fill_fifo();
    do_reset(4'h3);
    cmd(CMD_LOAD_LOW, 8'h00);
    cmd(CMD_LOAD_HIGH, 8'h00);
    addr = 19'h00000;
    stall = 1'b1;
    for (int i = 0; i < 8; i++) wr(i[7:0]);
    cmd(CMD_WRITE, 8'hEE);
    idle(6);
    check({host_ready_o, sram_write_valid_o}, 2'h1);
    stall = 1'b0;
    idle(14);
    check({host_ready_o, sram_write_valid_o}, 2'h2);
    wr(8'h77);
    compare_log();
  endtask
  initial begin
    foreach (cfg_list[i]) run_modes(cfg_list[i]);
    fill_fifo();
    summarize();
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      summarize();
    end
  end
endmodule
